// >>> rtl/amsx_exec.sv
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "amsx_params.svh"

// Behaviour
// - Subtract adds two's complement of source to destination; carry out flips carry.
// - Add (function 110) sums source and destination; carry out flips carry.
// - AND (function 111) ands both accumulators; operation never flips carry.
// - Multiply, divide and stack ops decode from I/O format with device code 1.
// - Multiply forms accumulator one times two plus zero; two unchanged.
// - Multiply puts high half in accumulator zero, low half in one.
// - Divide takes zero:one as 32-bit dividend, divided by accumulator two.
// - Divide leaves quotient in accumulator one, remainder in zero.
// - Divide overflows if zero exceeds two: carry set, abandon; else carry cleared.
// - Stack and frame pointers are 15-bit registers.
// - A return block is five consecutive memory words.
// - Push increments stack pointer, then writes accumulator at new pointer.
// - Pop reads accumulator at stack pointer, then decrements pointer.
// - Subroutine call puts program counter plus one into accumulator three.
// - Save pushes accumulators zero to two, frame pointer, then carry with three.
// - After save, pointers update and accumulator three holds new frame pointer.
// - Return reads the block located by the frame pointer.
// - Return restores pc, carry, accumulators, pointers; three gets restored frame pointer.
// - Carry field: 00 keep, 01 clear, 10 set, 11 invert.
// - Shift field: 01 rotate left, 10 rotate right, 11 swap bytes, 00 none.
// - Skip field tests shifter carry and result; true skip adds one pc step.
// - No-load flag blocks the writeback but the skip still evaluates.
module amsx_exec
    import amsx_pkg::*;
#(
    parameter int PTR_W = 15
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             mem_req,
    output amsx_mem_s        mem_cmd,
    input  wire logic [15:0] mem_rdata,
    input  wire logic        mem_ack,
    output logic             busy
);

    // ==========================================
    // Parameter check.
    if (PTR_W != 15) begin : g_bad_width
        $error("PTR_W must be 15.");
    end

    // ==========================================
    // State.
    logic [15:0]  acc [4];
    logic [14:0]  pc;
    logic [14:0]  sp;
    logic [14:0]  fp;
    logic [14:0]  tmp_fp;
    logic         carry;
    logic         skip_flag;
    logic         illegal;
    logic [15:0]  ir;
    amsx_state_e  state;
    amsx_op_e     op;
    logic [2:0]   step;
    logic [4:0]   div_cnt;
    logic [15:0]  div_r;
    logic [15:0]  div_q;
    logic         wr_pend;
    logic [7:0]   wr_addr;
    logic [31:0]  rd_mux;
    logic         bus_go;
    logic         wr_ok;

    // ==========================================
    // Bus slave.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign bus_go    = hsel && htrans[1] && hready;
    assign wr_ok     = wr_pend && (state == ST_IDLE);
    assign busy      = (state != ST_IDLE);

    always_comb begin
        case (haddr[7:0])
            `AMSX_A_AC0:    rd_mux = {16'h0000, acc[0]};
            `AMSX_A_AC1:    rd_mux = {16'h0000, acc[1]};
            `AMSX_A_AC2:    rd_mux = {16'h0000, acc[2]};
            `AMSX_A_AC3:    rd_mux = {16'h0000, acc[3]};
            `AMSX_A_PC:     rd_mux = {17'h00000, pc};
            `AMSX_A_SP:     rd_mux = {17'h00000, sp};
            `AMSX_A_FP:     rd_mux = {17'h00000, fp};
            `AMSX_A_CARRY:  rd_mux = {31'h00000000, carry};
            `AMSX_A_INSTR:  rd_mux = {16'h0000, ir};
            `AMSX_A_STATUS: rd_mux = {29'h00000000, illegal, skip_flag, busy};
            default:        rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata  <= 32'h00000000;
        end else begin
            wr_pend <= bus_go && hwrite;
            wr_addr <= haddr[7:0];
            if (bus_go && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ==========================================
    // Decode.
    function automatic amsx_op_e decode(input logic [15:0] w);
        amsx_op_e o;
        o = OP_BAD;
        if (w[15] && w[10:8] >= `AMSX_FN_SUB) begin
            o = OP_ALU;
        end else if (!w[15] && w[14:13] == `AMSX_IO_CLASS && w[5:0] == `AMSX_DEV_CODE) begin
            case (w[10:8])
                `AMSX_SUB_MUL:  o = OP_MUL;
                `AMSX_SUB_DIV:  o = OP_DIV;
                `AMSX_SUB_PUSH: o = OP_PUSH;
                `AMSX_SUB_POP:  o = OP_POP;
                `AMSX_SUB_SAVE: o = OP_SAVE;
                `AMSX_SUB_RET:  o = OP_RET;
                `AMSX_SUB_CALL: o = OP_CALL;
                default:        o = OP_BAD;
            endcase
        end
        return o;
    endfunction

    // ==========================================
    // Arithmetic, shifter and skip.
    logic [15:0] a_s;
    logic [15:0] a_d;
    logic [16:0] sum;
    logic [16:0] shv;
    logic        c0;
    logic        cin;
    logic        skip;

    always_comb begin
        a_s = acc[ir[14:13]];
        a_d = acc[ir[12:11]];
        case (ir[5:4])
            2'h1:    c0 = 1'b0;
            2'h2:    c0 = 1'b1;
            2'h3:    c0 = ~carry;
            default: c0 = carry;
        endcase
        case (ir[10:8])
            `AMSX_FN_SUB: sum = {1'b0, a_d} + {1'b0, ~a_s} + 17'h00001;
            `AMSX_FN_ADD: sum = {1'b0, a_d} + {1'b0, a_s};
            default:      sum = {1'b0, a_d & a_s};
        endcase
        cin = sum[16] ? ~c0 : c0;
        case (ir[7:6])
            2'h1:    shv = {sum[15:0], cin};
            2'h2:    shv = {sum[0], cin, sum[15:1]};
            2'h3:    shv = {cin, sum[7:0], sum[15:8]};
            default: shv = {cin, sum[15:0]};
        endcase
        case (ir[2:0])
            3'h1:    skip = 1'b1;
            3'h2:    skip = !shv[16];
            3'h3:    skip = shv[16];
            3'h4:    skip = (shv[15:0] == 16'h0000);
            3'h5:    skip = (shv[15:0] != 16'h0000);
            3'h6:    skip = !shv[16] || (shv[15:0] == 16'h0000);
            3'h7:    skip = shv[16] && (shv[15:0] != 16'h0000);
            default: skip = 1'b0;
        endcase
    end

    // ==========================================
    // Multiply and divide step.
    logic [31:0] prod;
    logic [16:0] dtry;
    logic [16:0] dsub;
    logic        dge;

    always_comb begin
        prod = {16'h0000, acc[1]} * {16'h0000, acc[2]} + {16'h0000, acc[0]};
        dtry = {div_r, div_q[15]};
        dsub = dtry - {1'b0, acc[2]};
        dge  = (dtry >= {1'b0, acc[2]});
    end

    // ==========================================
    // Memory step.
    logic [14:0] m_addr;
    logic [15:0] m_wdata;
    logic        m_we;
    logic        m_last;

    always_comb begin
        m_addr  = sp;
        m_wdata = 16'h0000;
        m_we    = 1'b0;
        m_last  = 1'b1;
        case (op)
            OP_PUSH: begin
                m_we    = 1'b1;
                m_wdata = acc[ir[12:11]];
            end
            OP_SAVE: begin
                m_we   = 1'b1;
                m_addr = sp + 15'(step) + 15'h0001;
                m_last = (step == `AMSX_BLK_LAST);
                case (step)
                    3'h0:    m_wdata = acc[0];
                    3'h1:    m_wdata = acc[1];
                    3'h2:    m_wdata = acc[2];
                    3'h3:    m_wdata = {1'b0, fp};
                    default: m_wdata = {carry, acc[3][14:0]};
                endcase
            end
            OP_RET: begin
                m_addr = fp - 15'(step);
                m_last = (step == `AMSX_BLK_LAST);
            end
            default: ;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_req <= 1'b0;
            mem_cmd <= '0;
        end else if (state == ST_ISSUE) begin
            mem_req <= 1'b1;
            mem_cmd <= '{we: m_we, addr: m_addr, wdata: m_wdata};
        end else if (state == ST_WAIT && mem_ack) begin
            mem_req <= 1'b0;
        end
    end

    // ==========================================
    // Sequencer and processor registers.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                acc[i] <= 16'h0000;
            end
            pc        <= `AMSX_PC_RST;
            sp        <= `AMSX_SP_RST;
            fp        <= `AMSX_FP_RST;
            tmp_fp    <= 15'h0000;
            carry     <= 1'b0;
            skip_flag <= 1'b0;
            illegal   <= 1'b0;
            ir        <= 16'h0000;
            op        <= OP_BAD;
            state     <= ST_IDLE;
            step      <= 3'h0;
            div_cnt   <= 5'h00;
            div_r     <= 16'h0000;
            div_q     <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (wr_ok) begin
                        case (wr_addr)
                            `AMSX_A_AC0:    acc[0] <= hwdata[15:0];
                            `AMSX_A_AC1:    acc[1] <= hwdata[15:0];
                            `AMSX_A_AC2:    acc[2] <= hwdata[15:0];
                            `AMSX_A_AC3:    acc[3] <= hwdata[15:0];
                            `AMSX_A_PC:     pc <= hwdata[14:0];
                            `AMSX_A_SP:     sp <= hwdata[14:0];
                            `AMSX_A_FP:     fp <= hwdata[14:0];
                            `AMSX_A_CARRY:  carry <= hwdata[0];
                            `AMSX_A_STATUS: illegal <= illegal && !hwdata[2];
                            `AMSX_A_INSTR: begin
                                ir    <= hwdata[15:0];
                                op    <= decode(hwdata[15:0]);
                                step  <= 3'h0;
                                state <= ST_EXEC;
                            end
                            default: ;
                        endcase
                    end
                end
                ST_EXEC: begin
                    state <= ST_IDLE;
                    pc    <= pc + 15'h0001;
                    case (op)
                        OP_ALU: begin
                            if (!ir[3]) begin
                                acc[ir[12:11]] <= shv[15:0];
                                carry          <= shv[16];
                            end
                            skip_flag <= skip;
                            pc        <= pc + (skip ? 15'h0002 : 15'h0001);
                        end
                        OP_MUL:  {acc[0], acc[1]} <= prod;
                        OP_DIV: begin
                            if (acc[0] > acc[2]) begin
                                carry <= 1'b1;
                            end else begin
                                carry   <= 1'b0;
                                div_r   <= acc[0];
                                div_q   <= acc[1];
                                div_cnt <= 5'h00;
                                pc      <= pc;
                                state   <= ST_DIV;
                            end
                        end
                        OP_PUSH: begin
                            sp    <= sp + 15'h0001;
                            pc    <= pc;
                            state <= ST_ISSUE;
                        end
                        OP_POP, OP_SAVE, OP_RET: begin
                            pc    <= pc;
                            state <= ST_ISSUE;
                        end
                        OP_CALL: begin
                            acc[3] <= {1'b0, pc + 15'h0001};
                            pc     <= acc[ir[12:11]][14:0];
                        end
                        default: illegal <= 1'b1;
                    endcase
                end
                ST_DIV: begin
                    div_r   <= dge ? dsub[15:0] : dtry[15:0];
                    div_q   <= {div_q[14:0], dge};
                    div_cnt <= div_cnt + 5'h01;
                    if (div_cnt == `AMSX_DIV_LAST) begin
                        acc[0] <= dge ? dsub[15:0] : dtry[15:0];
                        acc[1] <= {div_q[14:0], dge};
                        pc     <= pc + 15'h0001;
                        state  <= ST_IDLE;
                    end
                end
                ST_ISSUE: state <= ST_WAIT;
                ST_WAIT: begin
                    if (mem_ack) begin
                        if (op == OP_POP) acc[ir[12:11]] <= mem_rdata;
                        if (op == OP_RET) begin
                            case (step)
                                3'h0:    {carry, pc} <= mem_rdata;
                                3'h1:    tmp_fp <= mem_rdata[14:0];
                                3'h2:    acc[2] <= mem_rdata;
                                3'h3:    acc[1] <= mem_rdata;
                                default: acc[0] <= mem_rdata;
                            endcase
                        end
                        if (m_last) begin
                            state <= ST_IDLE;
                            case (op)
                                OP_POP: begin
                                    sp <= sp - 15'h0001;
                                    pc <= pc + 15'h0001;
                                end
                                OP_SAVE: begin
                                    sp     <= sp + `AMSX_BLK_WORDS;
                                    fp     <= sp + `AMSX_BLK_WORDS;
                                    acc[3] <= {1'b0, sp + `AMSX_BLK_WORDS};
                                    pc     <= pc + 15'h0001;
                                end
                                OP_RET: begin
                                    sp     <= fp - `AMSX_BLK_WORDS;
                                    fp     <= tmp_fp;
                                    acc[3] <= {1'b0, tmp_fp};
                                end
                                default: pc <= pc + 15'h0001;
                            endcase
                        end else begin
                            step  <= step + 3'h1;
                            state <= ST_ISSUE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> common/amsx_params.svh
`ifndef AMSX_PARAMS_SVH
`define AMSX_PARAMS_SVH

// ==========================================
// Register byte offsets.
`define AMSX_A_AC0     8'h00
`define AMSX_A_AC1     8'h04
`define AMSX_A_AC2     8'h08
`define AMSX_A_AC3     8'h0c
`define AMSX_A_PC      8'h10
`define AMSX_A_SP      8'h14
`define AMSX_A_FP      8'h18
`define AMSX_A_CARRY   8'h1c
`define AMSX_A_INSTR   8'h20
`define AMSX_A_STATUS  8'h24

// ==========================================
// Reset values.
`define AMSX_PC_RST    15'h0000
`define AMSX_SP_RST    15'h0000
`define AMSX_FP_RST    15'h0000

// ==========================================
// Instruction fields and codes.
`define AMSX_FN_SUB    3'h5
`define AMSX_FN_ADD    3'h6
`define AMSX_FN_AND    3'h7
`define AMSX_IO_CLASS  2'h3
`define AMSX_DEV_CODE  6'h01
`define AMSX_SUB_MUL   3'h0
`define AMSX_SUB_DIV   3'h1
`define AMSX_SUB_PUSH  3'h2
`define AMSX_SUB_POP   3'h3
`define AMSX_SUB_SAVE  3'h4
`define AMSX_SUB_RET   3'h5
`define AMSX_SUB_CALL  3'h6

// ==========================================
// Counts.
`define AMSX_DIV_LAST  5'd15
`define AMSX_BLK_LAST  3'd4
`define AMSX_BLK_WORDS 15'd5

`endif

// >>> common/amsx_pkg.sv
`default_nettype none
package amsx_pkg;

    // ==========================================
    // Types.
    typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_DIV, ST_ISSUE, ST_WAIT} amsx_state_e;

    typedef enum logic [3:0] {
        OP_BAD, OP_ALU, OP_MUL, OP_DIV, OP_PUSH, OP_POP, OP_SAVE, OP_RET, OP_CALL
    } amsx_op_e;

    typedef struct packed {
        logic        we;
        logic [14:0] addr;
        logic [15:0] wdata;
    } amsx_mem_s;

endpackage
`default_nettype wire

// >>> tb/amsx_exec_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker for the execution unit.
module amsx_exec_monitor
    import amsx_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        mem_req,
    input wire amsx_mem_s   mem_cmd,
    input wire logic        mem_ack,
    input wire logic        busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic ins_wr;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ins_wr <= 1'b0;
        end else begin
            ins_wr <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h20;
        end
    end
    wire logic io_go = ins_wr && !busy && hwdata[15:13] == 3'b011 && hwdata[5:0] == 6'h01;
    sequence s_wr_done;
        mem_req && mem_ack && mem_cmd.we;
    endsequence
    sequence s_rd_done;
        mem_req && mem_ack && !mem_cmd.we;
    endsequence
    sequence s_gap_req;
        !mem_req ##1 mem_req;
    endsequence
    a_cmd_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
        else $error("memory command moved before ack");
    a_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("memory request held after ack");
    a_req_busy: assert property (mem_req |-> busy)
        else $error("memory request while idle");
    a_block_up: assert property (s_wr_done ##1 s_gap_req ##0 mem_cmd.we
        |-> mem_cmd.addr == $past(mem_cmd.addr, 2) + 15'h1) else $error("block write not ascending");
    a_block_down: assert property (s_rd_done ##1 s_gap_req ##0 !mem_cmd.we
        |-> mem_cmd.addr == $past(mem_cmd.addr, 2) - 15'h1) else $error("block read not descending");
    a_mul_once: assert property (io_go && hwdata[10:8] == 3'h0 |=> busy ##1 !busy)
        else $error("multiply span wrong");
    a_div_span: assert property (io_go && hwdata[10:8] == 3'h1 |=> (busy ##1 !busy)
        or (busy[*8] ##1 busy[*8] ##1 busy ##1 !busy)) else $error("divide span wrong");
    a_push_write: assert property (io_go && hwdata[10:8] == 3'h2 |-> ##[2:4] (mem_req && mem_cmd.we))
        else $error("push issued no write");
    a_pop_read: assert property (io_go && hwdata[10:8] == 3'h3 |-> ##[2:4] (mem_req && !mem_cmd.we))
        else $error("pop issued no read");
endmodule
bind amsx_exec amsx_exec_monitor u_mon (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .mem_req,
    .mem_cmd, .mem_ack, .busy);
`default_nettype wire

// >>> tb/amsx_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Stack memory that answers after a varying delay.
module amsx_mem_model
    import amsx_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rst,
    input  wire logic      mem_req,
    input  wire amsx_mem_s mem_cmd,
    output logic [15:0]    mem_rdata,
    output logic           mem_ack
);
    logic [15:0] words [0:32767];
    logic [1:0]  waits;
    logic [1:0]  pace;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0;
            waits <= 2'h0;
            pace <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                waits <= waits + 2'h1;
                if (waits == pace) begin
                    mem_ack <= 1'b1;
                    waits <= 2'h0;
                    pace <= pace + 2'h1;
                    if (mem_cmd.we) words[mem_cmd.addr] <= mem_cmd.wdata;
                    else mem_rdata <= words[mem_cmd.addr];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import amsx_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b1;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] seed = 32'h00016fc3;
    logic [31:0] rv;
    logic [31:0] p;
    logic [15:0] ac [4];
    logic [15:0] blk [5];
    logic [15:0] ins;
    logic [14:0] pc0;
    logic [14:0] sp0;
    logic [14:0] fp0;
    logic [17:0] r;
    logic        c0;
    int          fails = 0;
    int          num_checks = 0;
    wire logic        hready;
    wire logic [31:0] hrdata;
    wire logic        mem_req;
    wire logic        mem_ack;
    wire logic [15:0] mem_rdata;
    wire amsx_mem_s   mem_cmd;
    amsx_exec dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready),
        .hresp(), .hrdata, .mem_req, .mem_cmd, .mem_rdata, .mem_ack, .busy());
    amsx_mem_model mem (.mclk, .rst, .mem_req, .mem_cmd, .mem_rdata, .mem_ack);
    // ==========
    // Reference functions and bus tasks.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] io(input logic [2:0] op, input logic [1:0] a);
        return {1'b0, 2'b11, a, op, 2'b00, 6'h01};
    endfunction
    function automatic logic [17:0] alu_ref(input logic [15:0] i, input logic [15:0] s, input logic [15:0] d,
                                            input logic c);
        logic [16:0] v;
        logic        k;
        c = i[5] ? (i[4] ? ~c : 1'b1) : (i[4] ? 1'b0 : c);
        v = (i[10:8] == 3'h5) ? {1'b0, d} + {1'b0, ~s} + 17'h1
          : (i[10:8] == 3'h6) ? {1'b0, d} + {1'b0, s} : {1'b0, d & s};
        v[16] = v[16] ^ c;
        case (i[7:6])
            2'b01: v = {v[15:0], v[16]};
            2'b10: v = {v[0], v[16:1]};
            2'b11: v = {v[16], v[7:0], v[15:8]};
            default: ;
        endcase
        k = i[2] ? (i[1] ? (i[0] ? v[16] && |v[15:0] : !v[16] || ~|v[15:0]) : i[0] ^ ~|v[15:0])
          : (i[1] ? i[0] ^ !v[16] : i[0]);
        return {k, v};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rv);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, rv);
        check(rv, e);
    endtask
    task automatic idle();
        @(posedge mclk);
        do bus(1'b0, 8'h24, 32'h0, rv); while (rv[0] !== 1'b0);
    endtask
    task automatic run(input logic [15:0] i);
        wr(8'h20, {16'h0, i});
        idle();
    endtask
    task automatic load(input logic c);
        for (int i = 0; i < 4; i++) wr(8'(i * 4), {16'h0, ac[i]});
        wr(8'h1c, {31'h0, c});
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========
    // Clock, watchdog and test sequence.
    initial begin
        forever #25 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 13; i++) chk(8'(i * 4), 32'h0);
        $display("reset test done");
        for (int n = 0; n < 48; n++) begin
            foreach (ac[i]) ac[i] = 16'(rnd());
            c0 = 1'(rnd());
            ins = {1'b1, 15'(rnd())};
            ins[10:8] = 3'h5 + 3'(n % 3);
            ins[2:0] = 3'(n);
            if (ins[3] && ins[2:0] == 3'h0) ins[3] = 1'b0;
            if (n % 5 == 0) ac[ins[12:11]] = ~ac[ins[14:13]];
            load(c0);
            bus(1'b0, 8'h10, 32'h0, rv);
            pc0 = rv[14:0];
            run(ins);
            r = alu_ref(ins, ac[ins[14:13]], ac[ins[12:11]], c0);
            if (!ins[3]) {c0, ac[ins[12:11]]} = r[16:0];
            for (int i = 0; i < 4; i++) chk(8'(i * 4), {16'h0, ac[i]});
            chk(8'h1c, {31'h0, c0});
            chk(8'h10, {17'h0, pc0 + 15'(r[17] + 1)});
            chk(8'h24, {30'h0, r[17], 1'b0});
        end
        $display("alu test done");
        for (int n = 0; n < 6; n++) begin
            foreach (ac[i]) ac[i] = (n == 0) ? 16'hffff : 16'(rnd());
            load(1'b0);
            run(io(3'h0, 2'h0));
            p = 32'(ac[1]) * 32'(ac[2]) + 32'(ac[0]);
            chk(8'h00, {16'h0, p[31:16]});
            chk(8'h04, {16'h0, p[15:0]});
            chk(8'h08, {16'h0, ac[2]});
        end
        for (int n = 0; n < 8; n++) begin
            foreach (ac[i]) ac[i] = 16'(rnd());
            ac[2] = {2'b0, ac[2][13:0]} | 16'h1;
            ac[0] = n[0] ? ac[2] + 16'(n) : ac[0] % ac[2];
            load(1'b0);
            wr(8'h20, {16'h0, io(3'h1, 2'h0)});
            if (!n[0]) wr(8'h0c, 32'h1234);
            idle();
            p = {ac[0], ac[1]};
            if (!n[0]) {ac[0], ac[1]} = {16'(p % ac[2]), 16'(p / ac[2])};
            for (int i = 0; i < 4; i++) chk(8'(i * 4), {16'h0, ac[i]});
            chk(8'h1c, {31'h0, n[0]});
        end
        $display("multiply and divide test done");
        foreach (ac[i]) ac[i] = 16'(rnd());
        load(1'b1);
        sp0 = 15'h7ffd;
        wr(8'h14, {17'h0, sp0});
        for (int i = 0; i < 4; i++) begin
            run(io(3'h2, 2'(i)));
            sp0 = sp0 + 15'h1;
            check({16'h0, mem.words[sp0]}, {16'h0, ac[i]});
        end
        chk(8'h14, {17'h0, sp0});
        for (int i = 0; i < 4; i++) run(io(3'h3, 2'(i)));
        for (int i = 0; i < 4; i++) chk(8'(i * 4), {16'h0, ac[3 - i]});
        chk(8'h14, {17'h0, sp0 - 15'h4});
        $display("push and pop test done");
        foreach (ac[i]) ac[i] = 16'(rnd());
        load(1'b1);
        wr(8'h10, 32'h0123);
        run(io(3'h6, 2'h1));
        ac[3] = 16'h0124;
        chk(8'h0c, 32'h0124);
        sp0 = 15'h0100;
        fp0 = 15'h0040;
        wr(8'h14, {17'h0, sp0});
        wr(8'h18, {17'h0, fp0});
        run(io(3'h4, 2'h0));
        blk = '{ac[0], ac[1], ac[2], {1'b0, fp0}, {1'b1, ac[3][14:0]}};
        for (int i = 0; i < 5; i++) check({16'h0, mem.words[sp0 + 15'(i + 1)]}, {16'h0, blk[i]});
        for (int i = 3; i < 7; i++) chk(8'(i * 4), {17'h0, (i == 4) ? ac[1][14:0] + 15'h1 : sp0 + 15'h5});
        for (int i = 0; i < 4; i++) wr(8'(i * 4), rnd());
        wr(8'h1c, 32'h0);
        run(io(3'h5, 2'h0));
        for (int i = 0; i < 3; i++) chk(8'(i * 4), {16'h0, ac[i]});
        chk(8'h0c, {17'h0, fp0});
        chk(8'h10, 32'h0124);
        chk(8'h14, {17'h0, sp0});
        chk(8'h18, {17'h0, fp0});
        chk(8'h1c, 32'h1);
        $display("save and return test done");
        run(16'h6002);
        bus(1'b0, 8'h24, 32'h0, rv);
        check(rv & 32'h4, 32'h4);
        wr(8'h24, 32'h4);
        bus(1'b0, 8'h24, 32'h0, rv);
        check(rv & 32'h4, 32'h0);
        $display("device code test done");
        close_out();
    end
endmodule
`default_nettype wire
